// ### verilog/tic_timer.v
// Purpose: 16-bit timer in single-edge and difference capture modes
// Assumes: ce marks instruction clock cycles; APB slave on pclk
// Notes: Event and PWM modes only hold the counter still
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "tic_defines.vh"

module tic_timer #(
  parameter CW = 16,
  parameter AW = 8
) (
  // Clock, reset and clock enable
  input wire pclk,
  input wire presetn,
  input wire ce,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Capture pin
  input wire capture_input_pin,
  // Interrupt to the core
  output reg timer_interrupt
);

  // Difference capture states
  localparam [1:0] DS_IDLE = 2'h0;
  localparam [1:0] DS_WAIT = 2'h1;
  localparam [1:0] DS_COUNT = 2'h2;

  localparam [CW-1:0] CNT_ONES = {CW{1'b1}};
  localparam [CW-1:0] CNT_ZERO = {CW{1'b0}};
  localparam [CW-1:0] CNT_ONE = {{(CW-1){1'b0}}, 1'b1};

  // Control fields and global interrupt enable
  reg run_underflow_r;
  reg edge_select_r;
  reg mode_lo_r;
  reg mode_hi_r;
  reg timer_irq_enable_r;
  reg capture_pending_r;
  reg second_edge_r;
  reg gie_r;

  // Datapath and interrupt state
  reg [CW-1:0] timer_count_r;
  reg [CW-1:0] timer_count_nxt;
  reg [CW-1:0] reload_capture_reg_r;
  reg [1:0] irq_status_r;
  reg [1:0] irq_mask_r;
  reg [1:0] diff_st_r;
  reg [1:0] diff_st_nxt;

  // Combinational events
  reg cap_evt;
  reg und_evt;
  reg [31:0] rd_data;
  reg rd_hit;

  wire rise;
  wire fall;
  wire [1:0] mode;
  wire cap_mode;
  wire diff_mode;
  wire any_capture;
  wire cap_edge;
  wire first_edge;
  wire second_edge;
  wire apb_sample;
  wire apb_done;
  wire wr_done;
  wire wr_ctrl;
  wire wr_count;
  wire wr_reload;
  wire wr_status;
  wire wr_mask;
  wire wr_gie;
  wire cap_new;
  wire und_new;
  wire capture_pending_nxt;
  wire run_underflow_nxt;
  wire [1:0] irq_status_nxt;
  wire irq_nxt;

  // Pin synchroniser and edge detector
  tic_edge_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pin_in(capture_input_pin),
    .rise_r(rise),
    .fall_r(fall)
  );

  // Mode decode
  assign mode = {mode_hi_r, mode_lo_r};
  assign cap_mode = (mode == `TIC_MODE_CAPTURE);
  assign diff_mode = (mode == `TIC_MODE_DIFF);
  assign any_capture = cap_mode | diff_mode;

  assign cap_edge = edge_select_r ? fall : rise;
  assign first_edge = edge_select_r ? fall : rise;
  assign second_edge = second_edge_r ? fall : rise;

  // APB phases: sample in first access cycle, finish when pready
  assign apb_sample = psel & penable & ~pready;
  assign apb_done = psel & penable & pready;
  assign wr_done = apb_done & pwrite;
  assign wr_ctrl = wr_done & (paddr == `TIC_ADDR_CTRL);
  assign wr_count = wr_done & (paddr == `TIC_ADDR_COUNT);
  assign wr_reload = wr_done & (paddr == `TIC_ADDR_RELOAD);
  assign wr_status = wr_done & (paddr == `TIC_ADDR_IRQ_STATUS);
  assign wr_mask = wr_done & (paddr == `TIC_ADDR_IRQ_MASK);
  assign wr_gie = wr_done & (paddr == `TIC_ADDR_GIE);

  // Read mux and address decode
  always @* begin
    rd_data = 32'h00000000;
    rd_hit = 1'b1;
    case (paddr)
      `TIC_ADDR_CTRL: begin
        rd_data[`TIC_CTRL_RUN_UNDERFLOW] = run_underflow_r;
        rd_data[`TIC_CTRL_EDGE_SELECT] = edge_select_r;
        rd_data[`TIC_CTRL_MODE_LO] = mode_lo_r;
        rd_data[`TIC_CTRL_MODE_HI] = mode_hi_r;
        rd_data[`TIC_CTRL_IRQ_ENABLE] = timer_irq_enable_r;
        rd_data[`TIC_CTRL_CAPTURE_PENDING] = capture_pending_r;
        rd_data[`TIC_CTRL_SECOND_EDGE] = second_edge_r;
      end
      `TIC_ADDR_COUNT: begin
        rd_data[CW-1:0] = timer_count_r;
      end
      `TIC_ADDR_RELOAD: begin
        rd_data[CW-1:0] = reload_capture_reg_r;
      end
      `TIC_ADDR_IRQ_STATUS: begin
        rd_data[1:0] = irq_status_r;
      end
      `TIC_ADDR_IRQ_MASK: begin
        rd_data[1:0] = irq_mask_r;
      end
      `TIC_ADDR_GIE: begin
        rd_data[0] = gie_r;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Difference capture sequencing
  always @* begin
    diff_st_nxt = diff_st_r;
    case (diff_st_r)
      DS_IDLE: begin
        if (diff_mode) begin
          diff_st_nxt = DS_WAIT;
        end
      end
      DS_WAIT: begin
        if (first_edge) begin
          diff_st_nxt = DS_COUNT;
        end
      end
      DS_COUNT: begin
        if (second_edge) begin
          diff_st_nxt = DS_WAIT;
        end
      end
      default: begin
        diff_st_nxt = DS_IDLE;
      end
    endcase
    if (!diff_mode) begin
      diff_st_nxt = DS_IDLE;
    end
  end

  // Counter and capture events
  always @* begin
    timer_count_nxt = timer_count_r;
    cap_evt = 1'b0;
    und_evt = 1'b0;
    if (cap_mode) begin
      if (timer_count_r == CNT_ZERO) begin
        timer_count_nxt = CNT_ONES;
        und_evt = 1'b1;
      end else begin
        timer_count_nxt = timer_count_r - CNT_ONE;
      end
      cap_evt = cap_edge;
    end else if (diff_mode) begin
      if (diff_st_r == DS_WAIT && first_edge) begin
        timer_count_nxt = CNT_ZERO;
      end else if (diff_st_r == DS_COUNT) begin
        if (second_edge) begin
          cap_evt = 1'b1;
        end else begin
          timer_count_nxt = timer_count_r + CNT_ONE;
          und_evt = (timer_count_r == CNT_ONES);
        end
      end
    end
    if (wr_count) begin
      timer_count_nxt = pwdata[CW-1:0];
    end
  end

  // zero clears, one keeps, event wins; outside capture modes run_underflow_r takes the written bit
  assign capture_pending_nxt = (capture_pending_r
    & ~(wr_ctrl & ~pwdata[`TIC_CTRL_CAPTURE_PENDING])) | cap_evt;
  assign run_underflow_nxt = any_capture ?
    ((run_underflow_r & ~(wr_ctrl & ~pwdata[`TIC_CTRL_RUN_UNDERFLOW])) | und_evt) :
    (wr_ctrl ? pwdata[`TIC_CTRL_RUN_UNDERFLOW] : run_underflow_r);

  // event only when flag was clear
  assign cap_new = cap_evt & ~capture_pending_r;
  assign und_new = und_evt & ~run_underflow_r & any_capture;

  // each sticky bit set by its own event; set beats clear
  assign irq_status_nxt = (irq_status_r & ~({2{wr_status}} & pwdata[1:0]))
    | {und_new, cap_new};

  // enables and a live flag needed
  assign irq_nxt = timer_irq_enable_r & gie_r
    & |(irq_status_r & irq_mask_r & {run_underflow_r, capture_pending_r});

  // APB handshake and read data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (ce) begin
      pready <= apb_sample;
      if (apb_sample) begin
        pslverr <= ~rd_hit;
        prdata <= pwrite ? 32'h00000000 : rd_data;
      end else if (apb_done) begin
        pslverr <= 1'b0;
      end
    end
  end

  // Control register and global interrupt enable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_select_r <= 1'b0;
      mode_lo_r <= 1'b0;
      mode_hi_r <= 1'b0;
      timer_irq_enable_r <= 1'b0;
      second_edge_r <= 1'b0;
      capture_pending_r <= 1'b0;
      run_underflow_r <= 1'b0;
      gie_r <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        mode_lo_r <= pwdata[`TIC_CTRL_MODE_LO];
        mode_hi_r <= pwdata[`TIC_CTRL_MODE_HI];
        edge_select_r <= pwdata[`TIC_CTRL_EDGE_SELECT];
        timer_irq_enable_r <= pwdata[`TIC_CTRL_IRQ_ENABLE];
        second_edge_r <= pwdata[`TIC_CTRL_SECOND_EDGE];
      end
      if (wr_gie) begin
        gie_r <= pwdata[0];
      end
      capture_pending_r <= capture_pending_nxt;
      run_underflow_r <= run_underflow_nxt;
    end
  end

  // Counter, capture register and sequencer state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count_r <= `TIC_RST_COUNT;
      reload_capture_reg_r <= `TIC_RST_RELOAD;
      diff_st_r <= DS_IDLE;
    end else if (ce) begin
      timer_count_r <= timer_count_nxt;
      diff_st_r <= diff_st_nxt;
      if (cap_evt) begin
        reload_capture_reg_r <= timer_count_r;
      end else if (wr_reload) begin
        reload_capture_reg_r <= pwdata[CW-1:0];
      end
    end
  end

  // Interrupt status, mask and output
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_r <= `TIC_RST_IRQ;
      irq_mask_r <= `TIC_RST_IRQ;
      timer_interrupt <= 1'b0;
    end else if (ce) begin
      irq_status_r <= irq_status_nxt;
      if (wr_mask) begin
        irq_mask_r <= pwdata[1:0];
      end
      timer_interrupt <= irq_nxt;
    end
  end

endmodule // tic_timer

// ### pkg/tic_defines.vh
// Purpose: Shared constants for the timer input capture unit
// Assumes: 32-bit APB data, byte addresses, one word per register
// Notes: Included by its bare name from every design file
`ifndef TIC_DEFINES_VH
`define TIC_DEFINES_VH

// Register byte addresses
`define TIC_ADDR_CTRL 8'h00
`define TIC_ADDR_COUNT 8'h04
`define TIC_ADDR_RELOAD 8'h08
`define TIC_ADDR_IRQ_STATUS 8'h0c
`define TIC_ADDR_IRQ_MASK 8'h10
`define TIC_ADDR_GIE 8'h14

// Control register field positions
`define TIC_CTRL_RUN_UNDERFLOW 0
`define TIC_CTRL_EDGE_SELECT 1
`define TIC_CTRL_MODE_LO 2
`define TIC_CTRL_MODE_HI 3
`define TIC_CTRL_IRQ_ENABLE 4
`define TIC_CTRL_CAPTURE_PENDING 5
`define TIC_CTRL_SECOND_EDGE 6

// Interrupt status and mask field positions
`define TIC_IRQ_CAPTURE 0
`define TIC_IRQ_UNDERFLOW 1

// Mode encodings, high bit then low bit
`define TIC_MODE_EVENT 2'h0
`define TIC_MODE_CAPTURE 2'h1
`define TIC_MODE_PWM 2'h2
`define TIC_MODE_DIFF 2'h3

// Reset values
`define TIC_RST_CTRL 7'h00
`define TIC_RST_COUNT 16'h0000
`define TIC_RST_RELOAD 16'h0000
`define TIC_RST_IRQ 2'h0

// Latency of the APB slave in access-phase cycles
`define TIC_APB_WAIT 1

`endif

// ### verilog/tic_edge_sync.v
// Purpose: Synchronise the capture pin and report its edges
// Assumes: Pin is asynchronous to pclk
// Notes: Edge pulses last one enabled cycle
`timescale 1ns/1ps
`include "tic_defines.vh"

module tic_edge_sync (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  input wire ce,
  // Pin and edge pulses
  input wire pin_in,
  output reg rise_r,
  output reg fall_r
);

  reg meta_r;
  reg sync_r;
  reg prev_r;
  reg [2:0] fill_r;

  // Two-flop synchroniser, then a history flop for edges
  // Edges held off until history is filled: idle level is no edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
      fill_r <= 3'h0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else if (ce) begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
      fill_r <= {fill_r[1:0], 1'b1};
      rise_r <= fill_r[2] & sync_r & ~prev_r;
      fall_r <= fill_r[2] & ~sync_r & prev_r;
    end
  end

endmodule // tic_edge_sync

// ### testbench/tic_timer_assertions.sv
// Purpose: Port checks of the timer capture unit
// Assumes: ce high whenever a transfer is under way
// Notes: Bound to tic_timer at the foot
`timescale 1ns/1ps
`include "tic_defines.vh"
module tic_timer_assertions #(parameter AW = 8) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  input wire ce,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Interrupt
  input wire timer_interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Transfer phases
  sequence s_wait; psel && penable && !pready && ce; endsequence
  sequence s_done; psel && penable && pready; endsequence
  sequence s_off(a, b); s_done ##0 (pwrite && paddr == a && !pwdata[b]); endsequence
  chk_one_wait: assert property (s_wait ##1 ce |-> pready) else $error("pready late");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("pready long");
  chk_ready_inside: assert property (pready |-> psel && penable) else $error("pready idle");
  chk_bad_addr: assert property (s_done ##0 paddr[1:0] == 2'h0 |-> pslverr == (paddr > `TIC_ADDR_GIE))
    else $error("pslverr wrong");
  chk_write_zero: assert property (s_done ##0 pwrite |-> prdata == 32'h0) else $error("prdata on write");
  chk_rdata_hold: assert property (!$past(psel && penable && !pready) |-> $stable(prdata))
    else $error("prdata moved");
  chk_gie_gates: assert property (s_off(`TIC_ADDR_GIE, 0) |-> ##2 !timer_interrupt)
    else $error("irq with global off");
  chk_enable_gates: assert property (s_off(`TIC_ADDR_CTRL, 4) |-> ##2 !timer_interrupt)
    else $error("irq with enable off");
  chk_mask_gates: assert property (s_off(`TIC_ADDR_IRQ_MASK, 0) ##0 !pwdata[1] |-> ##2 !timer_interrupt)
    else $error("irq while masked");
endmodule // tic_timer_assertions
bind tic_timer tic_timer_assertions #(.AW(AW)) tic_timer_assertions_i (.pclk(pclk), .presetn(presetn), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer_interrupt(timer_interrupt));

// ### testbench/tic_pin_source.sv
// Purpose: Signal source on the capture pin
// Assumes: Pin idles high, as with a pull-up
// Notes: Called just after a rising edge
`timescale 1ns/1ps
module tic_pin_source (
  // Clock
  input wire pclk,
  // Capture pin
  output reg pin
);
  initial pin = 1'b1;
  task level(input logic v, input int n);
    pin <= v;
    repeat ((n < 2) ? 2 : n) @(posedge pclk);
  endtask
endmodule // tic_pin_source

// ### testbench/test_timer_input_capture_unit.sv
// Purpose: Self-checking bench of the timer capture unit
// Assumes: ce high except one freeze check; pin idles high
// Notes: Reads note their expectation in a queue
`timescale 1ns/1ps
`include "tic_defines.vh"
module test_timer_input_capture_unit;
  reg pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  reg [7:0] paddr = 0;
  reg [31:0] pwdata = 0, rd = 0, r1, ctl;
  reg [64:0] note;
  reg [64:0] q[$];
  wire [31:0] prdata;
  wire pready, pslverr, pin, timer_interrupt;
  int fails = 0, checked = 0, a, b;
  time t0;

  // Clock
  always #10 pclk = ~pclk;

  tic_timer tic_timer_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_input_pin(pin), .timer_interrupt(timer_interrupt));
  tic_pin_source tic_pin_source_i (.pclk(pclk), .pin(pin));

  task summarize();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // APB transfer; notes expected data, mask and error
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic [31:0] m, input logic er);
    q.push_back({er, m, w ? 32'h0 : d});
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1, ad, d, 32'hffffffff, 0);
  endtask

  task irq(input logic e);
    repeat (2) @(posedge pclk);
    cmp("timer_interrupt", {31'h0, e}, {31'h0, timer_interrupt});
  endtask

  // Count change over two reads seven cycles apart
  task drift(input logic [31:0] e);
    apb(0, `TIC_ADDR_COUNT, 0, 0, 0);
    r1 = rd;
    repeat (3) @(posedge pclk);
    apb(0, `TIC_ADDR_COUNT, 0, 0, 0);
    cmp("count drift", e, r1 - rd);
  endtask

  // Monitor: oldest note against each finished transfer
  always @(posedge pclk) begin
    if (pready === 1'b1 && q.size() > 0) begin
      note = q.pop_front();
      cmp("prdata", note[31:0] & note[63:32], prdata & note[63:32]);
      cmp("pslverr", {31'h0, note[64]}, {31'h0, pslverr});
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    summarize();
  end

  initial begin
    void'($urandom(32'h1f1e));
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (a = 0; a < 24; a += 4)
      apb(0, a[7:0], 0, 32'hffffffff, 0);
    apb(0, 8'h18, 0, 32'hffffffff, 1);
    apb(1, 8'h1c, 32'h5a, 32'hffffffff, 1);
    $display("test registers done");
    wr(`TIC_ADDR_RELOAD, 32'h1234);
    wr(`TIC_ADDR_COUNT, 32'h0005);
    wr(`TIC_ADDR_CTRL, 32'h04);
    repeat (12) @(posedge pclk);
    apb(0, `TIC_ADDR_CTRL, 32'h05, 32'h7f, 0);
    apb(0, `TIC_ADDR_COUNT, 32'hff00, 32'hff00, 0);
    apb(0, `TIC_ADDR_RELOAD, 32'h1234, 32'hffff, 0);
    wr(`TIC_ADDR_CTRL, 32'h04);
    drift(7);
    apb(0, `TIC_ADDR_COUNT, 0, 0, 0);
    r1 = rd;
    ce <= 1'b0;
    repeat (5) @(posedge pclk);
    ce <= 1'b1;
    apb(0, `TIC_ADDR_COUNT, 0, 0, 0);
    cmp("count frozen", 4, r1 - rd);
    wr(`TIC_ADDR_CTRL, 32'h00);
    drift(0);
    $display("test single capture count done");
    wr(`TIC_ADDR_IRQ_MASK, 32'h3);
    wr(`TIC_ADDR_GIE, 32'h1);
    wr(`TIC_ADDR_CTRL, 32'h14);
    wr(`TIC_ADDR_IRQ_STATUS, 32'h3);
    tic_pin_source_i.level(0, 4);
    t0 = $time;
    tic_pin_source_i.level(1, 8);
    irq(1);
    apb(0, `TIC_ADDR_CTRL, 32'h34, 32'h7e, 0);
    apb(0, `TIC_ADDR_RELOAD, 0, 0, 0);
    ctl = rd;
    wr(`TIC_ADDR_IRQ_STATUS, 32'h1);
    irq(0);
    wr(`TIC_ADDR_CTRL, 32'h36);
    // gap short, no underflows to tally
    a = ($time - t0) / 20;
    tic_pin_source_i.level(0, 8);
    irq(0);
    apb(0, `TIC_ADDR_RELOAD, 0, 0, 0);
    cmp("capture gap", a, ctl - rd);
    wr(`TIC_ADDR_CTRL, 32'h16);
    wr(`TIC_ADDR_CTRL, 32'h36);
    apb(0, `TIC_ADDR_CTRL, 32'h16, 32'h7e, 0);
    wr(`TIC_ADDR_IRQ_MASK, 32'h0);
    tic_pin_source_i.level(1, 6);
    tic_pin_source_i.level(0, 8);
    irq(0);
    wr(`TIC_ADDR_IRQ_MASK, 32'h3);
    irq(1);
    wr(`TIC_ADDR_GIE, 32'h0);
    irq(0);
    // Capture edge lands on the underflow cycle
    wr(`TIC_ADDR_CTRL, 32'h04);
    wr(`TIC_ADDR_IRQ_STATUS, 32'h3);
    wr(`TIC_ADDR_COUNT, 32'h0004);
    tic_pin_source_i.level(1, 8);
    apb(0, `TIC_ADDR_CTRL, 32'h25, 32'h7f, 0);
    apb(0, `TIC_ADDR_IRQ_STATUS, 32'h3, 32'h3, 0);
    apb(0, `TIC_ADDR_RELOAD, 32'h0, 32'hffff, 0);
    $display("test capture interrupt done");
    // Four edge pairings, random widths
    for (b = 0; b < 4; b++) begin
      ctl = {25'h0, b[0], 4'h0, b[1], 1'b0} | 32'h0c;
      wr(`TIC_ADDR_CTRL, 32'h0);
      tic_pin_source_i.level(b[1], 6);
      wr(`TIC_ADDR_CTRL, ctl);
      t0 = $time;
      tic_pin_source_i.level(!b[1], 2 + $urandom % 19);
      if (b[0] == b[1])
        tic_pin_source_i.level(b[0], 2 + $urandom % 19);
      a = ($time - t0) / 20 - 1;
      tic_pin_source_i.level(!b[0], 8);
      apb(0, `TIC_ADDR_RELOAD, a, 32'hffff, 0);
      apb(0, `TIC_ADDR_CTRL, ctl | 32'h20, 32'h7e, 0);
    end
    // Up-count wrap in difference mode raises the underflow flag
    wr(`TIC_ADDR_CTRL, 32'h4c);
    tic_pin_source_i.level(1, 6);
    wr(`TIC_ADDR_IRQ_STATUS, 32'h3);
    wr(`TIC_ADDR_COUNT, 32'hfffe);
    apb(0, `TIC_ADDR_CTRL, 32'h4d, 32'h7f, 0);
    apb(0, `TIC_ADDR_IRQ_STATUS, 32'h2, 32'h3, 0);
    $display("test difference capture done");
    summarize();
  end
endmodule // test_timer_input_capture_unit
